// *** hw/conv_seq_pkg.sv ***
/*
  package for the shunt/bus conversion sequencer: configuration field
  layout, mode codes, reset values, timing counts and carrier structs.
  assumes a single 10 MHz core clock.
*/
package conv_seq_pkg;

  // ----------------------------------------------------------------
  // configuration register layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 16;
  localparam int SW_RESET_BIT = 15;
  localparam int BUS_RANGE_BIT = 13;
  localparam int GAIN_LSB = 11;
  localparam int BUS_ADC_LSB = 7;
  localparam int SHUNT_ADC_LSB = 3;
  localparam int MODE_LSB = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h399f;

  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] MODE_SHUNT_TRIG = 3'h1;
  localparam logic [2:0] MODE_BUS_TRIG = 3'h2;
  localparam logic [2:0] MODE_BOTH_TRIG = 3'h3;
  localparam logic [2:0] MODE_ADC_OFF = 3'h4;
  localparam logic [2:0] MODE_SHUNT_CONT = 3'h5;
  localparam logic [2:0] MODE_BUS_CONT = 3'h6;
  localparam logic [2:0] MODE_BOTH_CONT = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int WAKE_US = 40;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int CNT_W = 12;
  // per-sample conversion time by resolution code, in cycles
  localparam logic [CNT_W-1:0] CONV_9B_CYC = 12'h005;
  localparam logic [CNT_W-1:0] CONV_10B_CYC = 12'h009;
  localparam logic [CNT_W-1:0] CONV_11B_CYC = 12'h011;
  localparam logic [CNT_W-1:0] CONV_12B_CYC = 12'h022;
  localparam logic [CNT_W-1:0] WAKE_CNT = CNT_W'(WAKE_CYC);
  localparam logic [7:0] MATH_CYC = 8'h02;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAKE, ST_SHUNT, ST_BUS, ST_MATH
  } seq_state_t;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] current;
    logic [31:0] power;
  } results_t;

  typedef struct packed {
    logic sample_shunt;
    logic sample_bus;
    logic [1:0] shunt_gain_sel;
    logic bus_range_32v;
  } afe_ctl_t;

endpackage : conv_seq_pkg

// *** hw/shunt_bus_conversion_sequencer.sv ***
/*
  conversion sequencer of a current and power monitor: mode handling,
  per-channel averaging, current/power math step after the conversions, ready flag.
  assumes a two-wire engine that delivers config writes and status
  reads as one-cycle strobes, and an analog front end whose samples
  arrive as same-clock words.
*/
// Behaviour
// - the reset bit in position 15 or a general-call reset restores power-up state.
// - mode 111 loops shunt averaging then bus averaging without end.
// - modes 001/101 convert only shunt and 010/110 only bus, continuously or once; 011 converts both once.
// - current and power are computed in a 2-cycle math step after conversions, before ready sets and the next cycle starts.
// - only a write from power-down straight to a converting mode waits 40 us before conversions are valid.
// - adc-off mode halts all conversion until another mode is written.
// - every write of a triggered mode starts one single shot, same value or not.
// - results stay readable and hold the last completed conversion.
// - the ready flag sets only after conversions, averaging and math finish.
// - ready clears on config write (not power-down/adc-off), status read or pin trigger.
// - the shunt gain selects 40, 80, 160 or 320 mV full scale.
// - the bus range selects 16 V or 32 V full scale.
// - shunt and bus resolution and averaging are chosen independently.
// - shunt and bus samples are taken at different times.
// - after reset the block runs 12-bit, 320 mV, 32 V, continuous both channels.
// - current and power are produced only with a nonzero calibration.
`timescale 1ns/1ps
module shunt_bus_conversion_sequencer
  import conv_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_wr,
  input wire logic [CFG_W-1:0] cfg_wdata,
  input wire logic general_call_reset,
  input wire logic status_rd,
  input wire logic convert_pin,
  input wire logic [15:0] calibration,
  input wire logic [15:0] adc_sample,
  output logic [CFG_W-1:0] cfg_rdata,
  output logic conversion_ready_flag,
  output results_t results,
  output afe_ctl_t afe_ctl,
  output logic busy
);

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    seq_state_t st;
    logic [CNT_W-1:0] tick;
    logic [7:0] samp;
    logic [22:0] acc;
    logic running;
    logic one_shot;
    logic ready;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    results_t res;
  } state_t;

  state_t s_r, s_nxt;

  logic [2:0] mode;
  logic [3:0] shunt_adc;
  logic [3:0] bus_adc;
  logic do_shunt;
  logic do_bus;
  logic trig_mode;
  logic pin_rise;
  logic soft_reset;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // low two bits select resolution; bit 3 selects 2^n averaging
  function automatic logic [CNT_W-1:0] conv_cycles(input logic [3:0] c);
    logic [CNT_W-1:0] r;
    r = CONV_12B_CYC;
    if (!c[3]) begin
      unique case (c[1:0])
        2'h0: r = CONV_9B_CYC;
        2'h1: r = CONV_10B_CYC;
        2'h2: r = CONV_11B_CYC;
        2'h3: r = CONV_12B_CYC;
      endcase
    end
    return r;
  endfunction : conv_cycles

  function automatic logic [7:0] num_samples(input logic [3:0] c);
    logic [7:0] n;
    n = 8'h01;
    if (c[3]) begin
      n = 8'(8'h01 << c[2:0]);
    end
    return n;
  endfunction : num_samples

  function automatic logic [15:0] avg_out(input logic [22:0] a,
                                          input logic [3:0] c);
    logic [15:0] v;
    v = a[15:0];
    if (c[3]) begin
      v = 16'(a >> c[2:0]);
    end
    return v;
  endfunction : avg_out

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  always_comb begin
    mode = s_r.cfg[MODE_LSB +: 3];
    shunt_adc = s_r.cfg[SHUNT_ADC_LSB +: 4];
    bus_adc = s_r.cfg[BUS_ADC_LSB +: 4];
    do_shunt = mode[0];
    do_bus = mode[1];
    trig_mode = !mode[2];
    pin_rise = s_r.pin_s2 && !s_r.pin_s3;
    soft_reset = general_call_reset ||
                 (cfg_wr && cfg_wdata[SW_RESET_BIT]);
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_comb begin
    logic [2:0] wmode;
    logic [47:0] prod;
    s_nxt = s_r;
    wmode = cfg_wdata[MODE_LSB +: 3];
    prod = 48'h0;
    s_nxt.pin_s1 = convert_pin;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_s3 = s_r.pin_s2;

    // ready clears first so a same-cycle completion below wins
    if (status_rd) begin
      s_nxt.ready = 1'b0;
    end
    if (cfg_wr && wmode != MODE_POWER_DOWN && wmode != MODE_ADC_OFF) begin
      s_nxt.ready = 1'b0;
    end
    if (pin_rise && trig_mode && mode != MODE_POWER_DOWN) begin
      s_nxt.ready = 1'b0;
      s_nxt.one_shot = 1'b1;
    end

    unique case (s_r.st)
      ST_IDLE: begin
        if ((s_r.running || s_nxt.one_shot) &&
            mode != MODE_ADC_OFF && mode != MODE_POWER_DOWN) begin
          s_nxt.st = do_shunt ? ST_SHUNT : ST_BUS;
          s_nxt.tick = do_shunt ? conv_cycles(shunt_adc)
                                : conv_cycles(bus_adc);
          s_nxt.samp = do_shunt ? num_samples(shunt_adc)
                                : num_samples(bus_adc);
          s_nxt.acc = 23'h0;
          s_nxt.one_shot = 1'b0;
        end
      end
      ST_WAKE: begin
        // conversions held off until the front end settles
        if (s_r.tick == CNT_W'(1)) begin
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.tick = s_r.tick - CNT_W'(1);
        end
      end
      ST_SHUNT, ST_BUS: begin
        if (s_r.tick == CNT_W'(1)) begin
          s_nxt.acc = s_r.acc + 23'(adc_sample);
          if (s_r.samp == 8'h01) begin
            if (s_r.st == ST_SHUNT) begin
              s_nxt.res.shunt = avg_out(s_nxt.acc, shunt_adc);
            end else begin
              s_nxt.res.bus = avg_out(s_nxt.acc, bus_adc);
            end
            // bus follows shunt, so samples are apart in time
            if (s_r.st == ST_SHUNT && do_bus) begin
              s_nxt.st = ST_BUS;
              s_nxt.tick = conv_cycles(bus_adc);
              s_nxt.samp = num_samples(bus_adc);
              s_nxt.acc = 23'h0;
            end else begin
              s_nxt.st = ST_MATH;
              s_nxt.tick = CNT_W'(MATH_CYC);
            end
          end else begin
            s_nxt.samp = s_r.samp - 8'h01;
            s_nxt.tick = (s_r.st == ST_SHUNT) ? conv_cycles(shunt_adc)
                                              : conv_cycles(bus_adc);
          end
        end else begin
          s_nxt.tick = s_r.tick - CNT_W'(1);
        end
      end
      ST_MATH: begin
        // math after the last sample, off the conversion path
        if (s_r.tick == CNT_W'(1)) begin
          if (calibration != 16'h0) begin
            prod = 48'(32'($signed(s_r.res.shunt) * $signed(calibration))
                   >>> 12);
            s_nxt.res.current = prod[15:0];
            s_nxt.res.power = 32'(prod[15:0] * s_r.res.bus);
          end else begin
            // no stale product left on show without a calibration
            s_nxt.res.current = 16'h0;
            s_nxt.res.power = 32'h0;
          end
          s_nxt.ready = 1'b1;
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.tick = s_r.tick - CNT_W'(1);
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // config writes abort any cycle in flight
    if (cfg_wr && !cfg_wdata[SW_RESET_BIT]) begin
      s_nxt.cfg = cfg_wdata;
      s_nxt.running = wmode[2] && wmode != MODE_ADC_OFF;
      s_nxt.one_shot = !wmode[2] && wmode != MODE_POWER_DOWN;
      if (wmode == MODE_ADC_OFF || wmode == MODE_POWER_DOWN) begin
        s_nxt.st = ST_IDLE;
      end else if (mode == MODE_POWER_DOWN) begin
        s_nxt.st = ST_WAKE;
        s_nxt.tick = WAKE_CNT;
      end else if (s_r.st != ST_WAKE) begin
        // a write during wake-up must not cut the settling time short
        s_nxt.st = ST_IDLE;
      end
    end

    if (soft_reset) begin
      s_nxt = '0;
      s_nxt.cfg = CFG_RESET;
      s_nxt.running = 1'b1;
      s_nxt.st = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{cfg: CFG_RESET, st: ST_IDLE, running: 1'b1,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  always_comb begin
    cfg_rdata = s_r.cfg;
    conversion_ready_flag = s_r.ready;
    results = s_r.res;
    busy = s_r.st != ST_IDLE;
    afe_ctl.sample_shunt = s_r.st == ST_SHUNT;
    afe_ctl.sample_bus = s_r.st == ST_BUS;
    afe_ctl.shunt_gain_sel = s_r.cfg[GAIN_LSB +: 2];
    afe_ctl.bus_range_32v = s_r.cfg[BUS_RANGE_BIT];
  end

endmodule : shunt_bus_conversion_sequencer

// *** tb/afe_model.sv ***
/*
  analog front end stand-in: answers sample strobes with set words.
  assumes the strobes come from the sequencer on core_clk.
*/
`timescale 1ns/1ps
module afe_model
  import conv_seq_pkg::*;
(
  input wire logic core_clk,
  input wire afe_ctl_t afe_ctl,
  input wire logic [15:0] shunt_val,
  input wire logic [15:0] bus_val,
  output logic [15:0] adc_sample
);
  // idle word moves every cycle so a stale read never matches
  logic [15:0] junk_r = 16'h5a5a;
  always @(posedge core_clk) junk_r <= ~junk_r + 16'h0001;
  assign adc_sample = afe_ctl.sample_shunt ? shunt_val :
    afe_ctl.sample_bus ? bus_val : junk_r;
endmodule : afe_model

// *** tb/conv_seq_monitor.sv ***
/*
  port checker for the conversion sequencer.
  assumes it is bound to the sequencer top and sees only its ports.
*/
`timescale 1ns/1ps
module conv_seq_monitor
  import conv_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_wr,
  input wire logic [CFG_W-1:0] cfg_wdata,
  input wire logic general_call_reset,
  input wire logic status_rd,
  input wire logic convert_pin,
  input wire logic [15:0] calibration,
  input wire logic [15:0] adc_sample,
  input wire logic [CFG_W-1:0] cfg_rdata,
  input wire logic conversion_ready_flag,
  input wire results_t results,
  input wire afe_ctl_t afe_ctl,
  input wire logic busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic smp = afe_ctl.sample_shunt | afe_ctl.sample_bus;
  wire logic rdy = conversion_ready_flag;
  wire logic quiet = !cfg_wr && !general_call_reset;
  wire logic off_wr = cfg_wr && !cfg_wdata[15] &&
    (cfg_wdata[2:0] == MODE_POWER_DOWN || cfg_wdata[2:0] == MODE_ADC_OFF);
  ready_late_a: assert property ($rose(rdy) |-> !smp)
    else $error("ready rose while sampling");
  status_clr_a: assert property (status_rd && !busy && quiet |=> !rdy)
    else $error("status read left ready set");
  cfg_clr_a: assert property (cfg_wr && !off_wr && !busy |=> !rdy)
    else $error("config write left ready set");
  off_keep_a: assert property (off_wr && rdy && !busy && !status_rd &&
    !general_call_reset |=> rdy)
    else $error("off write cleared ready");
  cfg_upd_a: assert property (cfg_wr && !cfg_wdata[15] && !general_call_reset
    |=> cfg_rdata == $past(cfg_wdata))
    else $error("config not taken");
  reset_cfg_a: assert property ((cfg_wr && cfg_wdata[15]) || general_call_reset
    |=> cfg_rdata == CFG_RESET && !rdy && results == '0)
    else $error("soft reset incomplete");
  adc_off_a: assert property ($past(cfg_rdata[2:0]) == MODE_ADC_OFF &&
    cfg_rdata[2:0] == MODE_ADC_OFF |-> !smp && !busy)
    else $error("activity while adc off");
  wake_a: assert property ($past(cfg_rdata[2:0]) == MODE_POWER_DOWN &&
    cfg_rdata[2:0] != MODE_POWER_DOWN |-> (!smp) [*8])
    else $error("sampled too soon after power-down");
  range_a: assert property (afe_ctl.shunt_gain_sel == cfg_rdata[12:11] &&
    afe_ctl.bus_range_32v == cfg_rdata[BUS_RANGE_BIT])
    else $error("front end ranges differ from config");
  hold_a: assert property (!busy && quiet |=> $stable(results))
    else $error("results moved while idle");
  cal_zero_a: assert property ($rose(rdy) && calibration == 16'h0000
    |-> results.current == 16'h0000 && results.power == 32'h0)
    else $error("current made without calibration");
endmodule : conv_seq_monitor

// *** tb/tb_shunt_bus_conversion_sequencer.sv ***
/*
  self-checking bench for the conversion sequencer with a front end
  model. assumes the package and design sources are compiled first.
*/
`timescale 1ns/1ps
module tb_shunt_bus_conversion_sequencer;
  import conv_seq_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, cfg_wr = 1'b0;
  logic general_call_reset = 1'b0, status_rd = 1'b0, convert_pin = 1'b0;
  logic [CFG_W-1:0] cfg_wdata = 16'h0000, cfg_rdata;
  logic [15:0] calibration = 16'h1000;
  logic [15:0] shunt_val = 16'h0123, bus_val = 16'h0456;
  wire logic [15:0] adc_sample;
  logic conversion_ready_flag, busy;
  results_t results;
  afe_ctl_t afe_ctl;
  int fail_count = 0, samples_checked = 0, seed = 44434;
  int sh_m = 'h123, bus_m = 'h456, cur, i, k, m;
  always #50 core_clk = ~core_clk;
  shunt_bus_conversion_sequencer i_dut (.core_clk(core_clk),
    .resetn(resetn), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .general_call_reset(general_call_reset), .status_rd(status_rd),
    .convert_pin(convert_pin), .calibration(calibration),
    .adc_sample(adc_sample), .cfg_rdata(cfg_rdata),
    .conversion_ready_flag(conversion_ready_flag), .results(results),
    .afe_ctl(afe_ctl), .busy(busy));
  afe_model i_afe (.core_clk(core_clk), .afe_ctl(afe_ctl),
    .shunt_val(shunt_val), .bus_val(bus_val), .adc_sample(adc_sample));
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic strobe(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : strobe
  task automatic write_cfg(input logic [15:0] d);
    @(negedge core_clk);
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask : write_cfg
  // bounded wait; a hang counts as a mismatch
  task automatic wait_ready();
    for (int n = 0; n < 4000; n++) begin
      @(negedge core_clk);
      if (conversion_ready_flag === 1'b1) return;
    end
    fail_count++;
    wrap_up();
  endtask : wait_ready
  task automatic check_results();
    cur = ((sh_m * int'(calibration)) >> 12) & 'hffff;
    check("shunt", results.shunt, 32'(sh_m));
    check("bus", results.bus, 32'(bus_m));
    check("current", results.current, 32'(cur));
    check("power", results.power, 32'(cur * bus_m));
  endtask : check_results
  initial begin
    calibration = (16'($random(seed)) & 16'h1fff) | 16'h0001;
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    check("cfg", cfg_rdata, CFG_RESET);
    check("gain", afe_ctl.shunt_gain_sel, 2'h3);
    wait_ready();
    check_results();
    strobe(status_rd);
    check("rd clr", conversion_ready_flag, 1'b0);
    wait_ready();
    // continuous modes first; ends on shunt-only trigger for the pin test
    for (i = 1; i < 7; i++) begin
      m = (i < 4) ? 8 - i : 7 - i;
      shunt_val = 16'($random(seed)) & 16'h0fff;
      bus_val = 16'($random(seed)) & 16'h0fff;
      if (m[0]) sh_m = shunt_val;
      if (m[1]) bus_m = bus_val;
      write_cfg({2'b00, i[0], 2'h2, 4'(i), 4'(i + 7), m[2:0]});
      check("wr clr", conversion_ready_flag, 1'b0);
      check("range", afe_ctl.bus_range_32v, i[0]);
      wait_ready();
      check_results();
      write_cfg(cfg_rdata);
      @(negedge core_clk);
      check("retrig", busy, 1'b1);
      wait_ready();
    end
    strobe(convert_pin);
    repeat (3) @(negedge core_clk);
    check("pin clr", conversion_ready_flag, 1'b0);
    wait_ready();
    write_cfg({13'h0700, MODE_ADC_OFF});
    repeat (50) @(negedge core_clk);
    check("off", {busy, conversion_ready_flag}, 2'h1);
    write_cfg({13'h0700, MODE_POWER_DOWN});
    check("pd keep", conversion_ready_flag, 1'b1);
    write_cfg({13'h0700, MODE_BOTH_CONT});
    for (k = 0; k < 600 && afe_ctl.sample_shunt !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    check("wake", k >= WAKE_CYC - 2 && k <= WAKE_CYC + 4, 1'b1);
    calibration = 16'h0000;
    write_cfg({13'h0700, MODE_BOTH_TRIG});
    wait_ready();
    check("cal0", results.current, 16'h0000);
    write_cfg(16'h8000);
    check("sw rst", {cfg_rdata, conversion_ready_flag}, {CFG_RESET, 1'b0});
    write_cfg({13'h0000, MODE_ADC_OFF});
    strobe(general_call_reset);
    check("gc rst", cfg_rdata, CFG_RESET);
    wrap_up();
  end
endmodule : tb_shunt_bus_conversion_sequencer
bind shunt_bus_conversion_sequencer conv_seq_monitor i_mon (
  .core_clk(core_clk), .resetn(resetn), .cfg_wr(cfg_wr),
  .cfg_wdata(cfg_wdata), .general_call_reset(general_call_reset),
  .status_rd(status_rd), .convert_pin(convert_pin),
  .calibration(calibration), .adc_sample(adc_sample),
  .cfg_rdata(cfg_rdata), .conversion_ready_flag(conversion_ready_flag),
  .results(results), .afe_ctl(afe_ctl), .busy(busy));
